// >>> pai_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pai_pin_model (
  // clock
  input wire logic clk_in,
  // device pin controls and bench commands
  input wire pai_pkg::pai_pin_ctrl_t ctrl_in,
  input wire logic [7:0] ext_en_in,
  input wire logic [7:0] ext_val_in,
  // resolved pin levels
  output logic [7:0] pin_out
);
  ////////////////////////////////////////////////////////////////
  // a floating pin must not look stable, so it toggles every cycle
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge clk_in) begin
    last_r <= pin_out;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ctrl_in.oe[i]) begin
        pin_out[i] = ctrl_in.drive[i];
      end else if (ext_en_in[i]) begin
        pin_out[i] = ext_val_in[i];
      end else if (ctrl_in.pull_en[i]) begin
        pin_out[i] = ~ctrl_in.pull_down[i];
      end else begin
        pin_out[i] = ~last_r[i];
      end
    end
  end
endmodule
`default_nettype wire

// >>> pai_pkg.sv
package pai_pkg;
  // register offsets (byte addresses on the local register port)
  localparam logic [3:0] OFF_SLEW = 4'h0;
  localparam logic [3:0] OFF_DRIVE = 4'h1;
  localparam logic [3:0] OFF_STATUS_CTRL = 4'h2;
  localparam logic [3:0] OFF_SOURCE_SEL = 4'h3;
  localparam logic [3:0] OFF_POLARITY = 4'h4;
  localparam logic [3:0] OFF_DIRECTION = 4'h5;
  localparam logic [3:0] OFF_PULL_EN = 4'h6;
  localparam logic [3:0] OFF_DATA = 4'h7;
  // implemented port bits: 7:6 and 3:0
  localparam logic [7:0] PORT_MASK = 8'hCF;
  localparam logic [7:0] IRQ_PIN_MASK = 8'h0F;
  // status/control field positions
  localparam int BIT_FLAG = 3;
  localparam int BIT_ACK = 2;
  localparam int BIT_IRQ_EN = 1;
  localparam int BIT_MODE = 0;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] oe;
    logic [7:0] slew;
    logic [7:0] strength;
    logic [7:0] pull_en;
    logic [7:0] pull_down;
  } pai_pin_ctrl_t;
endpackage

// >>> pai_port.sv
`timescale 1ns/1ps
`default_nettype none
module pai_port (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  // register port
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  // pins
  input wire logic [7:0] PIN_IN,
  output pai_pkg::pai_pin_ctrl_t PIN_CTRL_OUT,
  // interrupt
  output logic IRQ_OUT
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] slew_limit_bits_r;
  logic [7:0] drive_strength_bits_r;
  logic [7:0] pin_irq_source_select_r;
  logic [7:0] pin_irq_polarity_r;
  logic [7:0] direction_bits_r;
  logic [7:0] pull_enable_bits_r;
  logic [7:0] port_data_bits_r;
  logic pin_irq_flag_r;
  logic pin_irq_enable_r;
  logic edge_level_select_r;
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;
  logic [7:0] pin_prev_r;
  logic [7:0] active_now;
  logic [7:0] active_prev;
  logic edge_hit;
  logic level_hold;
  logic detect;
  logic ack_wr;
  logic [7:0] rdata_nxt;

  function automatic logic wr_at(input logic [3:0] a, input logic [3:0] off, input logic we);
    wr_at = we && (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser
  // only the second stage feeds logic; the third stage is the edge reference, not a sync stage
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
      pin_prev_r <= 8'h00;
    end else begin
      pin_meta_r <= PIN_IN;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reserved bits masked on write
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      slew_limit_bits_r <= pai_pkg::RESET_VALUE;
      drive_strength_bits_r <= pai_pkg::RESET_VALUE;
      pin_irq_source_select_r <= pai_pkg::RESET_VALUE;
      pin_irq_polarity_r <= pai_pkg::RESET_VALUE;
      direction_bits_r <= pai_pkg::RESET_VALUE;
      pull_enable_bits_r <= pai_pkg::RESET_VALUE;
      port_data_bits_r <= pai_pkg::RESET_VALUE;
      pin_irq_enable_r <= 1'b0;
      edge_level_select_r <= 1'b0;
    end else begin
      if (wr_at(ADDR_IN, pai_pkg::OFF_SLEW, WR_IN)) begin
        slew_limit_bits_r <= WDATA_IN & pai_pkg::PORT_MASK;
      end
      if (wr_at(ADDR_IN, pai_pkg::OFF_DRIVE, WR_IN)) begin
        drive_strength_bits_r <= WDATA_IN & pai_pkg::PORT_MASK;
      end
      if (wr_at(ADDR_IN, pai_pkg::OFF_SOURCE_SEL, WR_IN)) begin
        pin_irq_source_select_r <= WDATA_IN & pai_pkg::IRQ_PIN_MASK;
      end
      if (wr_at(ADDR_IN, pai_pkg::OFF_POLARITY, WR_IN)) begin
        pin_irq_polarity_r <= WDATA_IN & pai_pkg::IRQ_PIN_MASK;
      end
      if (wr_at(ADDR_IN, pai_pkg::OFF_DIRECTION, WR_IN)) begin
        direction_bits_r <= WDATA_IN & pai_pkg::PORT_MASK;
      end
      if (wr_at(ADDR_IN, pai_pkg::OFF_PULL_EN, WR_IN)) begin
        pull_enable_bits_r <= WDATA_IN & pai_pkg::PORT_MASK;
      end
      if (wr_at(ADDR_IN, pai_pkg::OFF_DATA, WR_IN)) begin
        port_data_bits_r <= WDATA_IN & pai_pkg::PORT_MASK;
      end
      if (wr_at(ADDR_IN, pai_pkg::OFF_STATUS_CTRL, WR_IN)) begin
        pin_irq_enable_r <= WDATA_IN[pai_pkg::BIT_IRQ_EN];
        edge_level_select_r <= WDATA_IN[pai_pkg::BIT_MODE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // only selected pins; polarity flips sense
  assign active_now = (pin_sync_r ^ ~pin_irq_polarity_r) & pin_irq_source_select_r;
  assign active_prev = (pin_prev_r ^ ~pin_irq_polarity_r) & pin_irq_source_select_r;
  assign edge_hit = |(active_now & ~active_prev);
  // level mode keeps detecting while active
  assign level_hold = edge_level_select_r && (|active_now);
  assign detect = edge_hit || level_hold;
  assign ack_wr = wr_at(ADDR_IN, pai_pkg::OFF_STATUS_CTRL, WR_IN) && WDATA_IN[pai_pkg::BIT_ACK];

  // set wins over acknowledge; flag ignores direct writes
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_irq_flag_r <= 1'b0;
    end else if (detect) begin
      pin_irq_flag_r <= 1'b1;
    end else if (ack_wr) begin
      pin_irq_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= (pin_irq_flag_r || detect) && pin_irq_enable_r && !(ack_wr && !detect)
                 && !(WR_IN && ADDR_IN == pai_pkg::OFF_STATUS_CTRL && !WDATA_IN[pai_pkg::BIT_IRQ_EN])
                 || (pin_irq_flag_r || detect) && !(ack_wr && !detect)
                    && wr_at(ADDR_IN, pai_pkg::OFF_STATUS_CTRL, WR_IN) && WDATA_IN[pai_pkg::BIT_IRQ_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin control outputs
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PIN_CTRL_OUT <= '0;
    end else begin
      PIN_CTRL_OUT.oe <= direction_bits_r;
      PIN_CTRL_OUT.drive <= port_data_bits_r & direction_bits_r;
      PIN_CTRL_OUT.slew <= slew_limit_bits_r & direction_bits_r;
      PIN_CTRL_OUT.strength <= drive_strength_bits_r & direction_bits_r;
      PIN_CTRL_OUT.pull_en <= pull_enable_bits_r & ~direction_bits_r;
      PIN_CTRL_OUT.pull_down <= pull_enable_bits_r & ~direction_bits_r
                                & pin_irq_source_select_r & pin_irq_polarity_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped reads zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (ADDR_IN)
      pai_pkg::OFF_SLEW: rdata_nxt = slew_limit_bits_r;
      pai_pkg::OFF_DRIVE: rdata_nxt = drive_strength_bits_r;
      pai_pkg::OFF_STATUS_CTRL: begin
        rdata_nxt[pai_pkg::BIT_FLAG] = pin_irq_flag_r;
        rdata_nxt[pai_pkg::BIT_IRQ_EN] = pin_irq_enable_r;
        rdata_nxt[pai_pkg::BIT_MODE] = edge_level_select_r;
      end
      pai_pkg::OFF_SOURCE_SEL: rdata_nxt = pin_irq_source_select_r;
      pai_pkg::OFF_POLARITY: rdata_nxt = pin_irq_polarity_r;
      pai_pkg::OFF_DIRECTION: rdata_nxt = direction_bits_r;
      pai_pkg::OFF_PULL_EN: rdata_nxt = pull_enable_bits_r;
      pai_pkg::OFF_DATA: rdata_nxt = ((port_data_bits_r & direction_bits_r)
                                      | (pin_sync_r & ~direction_bits_r)) & pai_pkg::PORT_MASK;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (RD_IN) begin
      RDATA_OUT <= rdata_nxt;
    end else begin
      RDATA_OUT <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // unselected pin never raises flag
  AST_UNSELECTED_QUIET: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (pin_irq_source_select_r == 8'h00) && !pin_irq_flag_r |=> !pin_irq_flag_r)
    else $error("flag set with no source selected");
  AST_EDGE_SETS_FLAG: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    edge_hit |=> pin_irq_flag_r)
    else $error("edge did not set flag");
  AST_ACK_CLEARS: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    ack_wr && !detect |=> !pin_irq_flag_r)
    else $error("acknowledge failed to clear flag");
  // level held keeps flag across acknowledge
  AST_LEVEL_HOLDS: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    edge_level_select_r && (|active_now) && ack_wr |=> pin_irq_flag_r)
    else $error("level mode flag cleared while active");
  AST_IRQ_GATED: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    IRQ_OUT |-> $past(pin_irq_flag_r || detect))
    else $error("request without detection");
  AST_IRQ_STEADY: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    pin_irq_flag_r && pin_irq_enable_r ##1 pin_irq_flag_r && pin_irq_enable_r |-> IRQ_OUT)
    else $error("request missing while flag and enable set");
  // no slew control for input pins
  AST_SLEW_INPUT: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (PIN_CTRL_OUT.slew & ~PIN_CTRL_OUT.oe) == 8'h00)
    else $error("slew applied to input");
  // pull-down only on enabled rising sources
  AST_PULLDOWN: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (PIN_CTRL_OUT.pull_down & ~$past(pin_irq_source_select_r & pin_irq_polarity_r)) == 8'h00)
    else $error("pull-down on non rising source");
  AST_PULL_OUTPUT: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (PIN_CTRL_OUT.pull_en & PIN_CTRL_OUT.oe) == 8'h00)
    else $error("pull enabled on output");
  AST_ACK_READS_ZERO: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    RD_IN && ADDR_IN == pai_pkg::OFF_STATUS_CTRL |=> !RDATA_OUT[pai_pkg::BIT_ACK])
    else $error("acknowledge bit read nonzero");

  ////////////////////////////////////////////////////////////////////////
  // pin control outputs lag their registers by one cycle, hence the $past terms
  // slew follows outputs
  AST_SLEW_FOLLOWS: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    PIN_CTRL_OUT.slew == $past(slew_limit_bits_r & direction_bits_r))
    else $error("slew control does not follow its register");
  AST_STRENGTH_INPUT: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (PIN_CTRL_OUT.strength & ~PIN_CTRL_OUT.oe) == 8'h00)
    else $error("drive strength applied to input");
  AST_RESERVED_BITS: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    ((slew_limit_bits_r | drive_strength_bits_r) & ~pai_pkg::PORT_MASK) == 8'h00)
    else $error("reserved slew or drive bit set");
  AST_FLAG_WRITE_IGNORED: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    wr_at(ADDR_IN, pai_pkg::OFF_STATUS_CTRL, WR_IN) && !WDATA_IN[pai_pkg::BIT_ACK] && !detect
    |=> pin_irq_flag_r == $past(pin_irq_flag_r))
    else $error("flag changed by a write without acknowledge");
  AST_FLAG_NEEDS_DETECT: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    $rose(pin_irq_flag_r) |-> $past(detect))
    else $error("flag set without detection");
  AST_ACK_LOSES: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    detect && ack_wr |=> pin_irq_flag_r)
    else $error("acknowledge won over detection");
  AST_IRQ_OFF: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    !pin_irq_enable_r |-> !IRQ_OUT)
    else $error("request raised while disabled");
  AST_LEVEL_SETS: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    level_hold |=> pin_irq_flag_r)
    else $error("held level did not set flag");
  AST_EDGE_ONLY: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    !edge_level_select_r && !edge_hit && !pin_irq_flag_r |=> !pin_irq_flag_r)
    else $error("flag set without edge in edge mode");
  AST_SELECT_UPPER: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    ((pin_irq_source_select_r | pin_irq_polarity_r) & ~pai_pkg::IRQ_PIN_MASK) == 8'h00)
    else $error("select or polarity bit set above pin 3");
  AST_PULLUP_FALLING: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (PIN_CTRL_OUT.pull_down & $past(~pin_irq_polarity_r)) == 8'h00)
    else $error("pull-down on falling polarity pin");
  AST_PULLDOWN_NEEDS_PULL: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (PIN_CTRL_OUT.pull_down & ~PIN_CTRL_OUT.pull_en) == 8'h00)
    else $error("pull-down without pull enable");
  AST_OE_FOLLOWS_DIR: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    PIN_CTRL_OUT.oe == $past(direction_bits_r))
    else $error("output enable does not follow direction");
  AST_DRIVE_INPUT: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (PIN_CTRL_OUT.drive & ~PIN_CTRL_OUT.oe) == 8'h00)
    else $error("drive level on input pin");
  AST_PREV_FOLLOWS: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    pin_prev_r == $past(pin_sync_r))
    else $error("edge reference not one cycle behind");
endmodule
`default_nettype wire

// >>> tb_pai_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pai_port;
  logic mclk, rst, wr, rd, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, pin, ext_en, ext_val;
  pai_pkg::pai_pin_ctrl_t ctrl;
  int failures, checked;
  localparam logic [3:0] SC = pai_pkg::OFF_STATUS_CTRL;

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  pai_port u_dut(.MCLK_IN(mclk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .PIN_IN(pin), .PIN_CTRL_OUT(ctrl), .IRQ_OUT(irq));
  pai_pin_model u_pins(.clk_in(mclk), .ctrl_in(ctrl), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .pin_out(pin));

  ////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic wait_irq(input logic exp);
    for (int n = 0; n < 12 && irq !== exp; n++) begin
      @(posedge mclk);
      #1;
    end
    chk({7'h00, irq}, {7'h00, exp});
    if (irq !== exp) begin
      finish_test();
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    idle(5000);
    failures++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    // pins 7:6 held low outside while inputs, so data reads are predictable
    ext_en = 8'hCF;
    ext_val = 8'h0F;
    failures = 0;
    checked = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 7; a++) rd_reg(a[3:0], 8'h00);
    rd_reg(pai_pkg::OFF_DATA, 8'h0F);
    rd_reg(4'h8, 8'h00);
    wr_reg(pai_pkg::OFF_SLEW, 8'hFF);
    wr_reg(pai_pkg::OFF_DRIVE, 8'hFF);
    rd_reg(pai_pkg::OFF_SLEW, 8'hCF);
    rd_reg(pai_pkg::OFF_DRIVE, 8'hCF);
    chk(ctrl.slew, 8'h00);
    chk(ctrl.strength, 8'h00);
    wr_reg(pai_pkg::OFF_DATA, 8'hC3);
    wr_reg(pai_pkg::OFF_DIRECTION, 8'hC0);
    wr_reg(pai_pkg::OFF_PULL_EN, 8'hFF);
    wr_reg(pai_pkg::OFF_SOURCE_SEL, 8'h01);
    idle(2);
    chk(ctrl.oe, 8'hC0);
    chk(ctrl.drive & 8'hC0, 8'hC0);
    chk(ctrl.slew, 8'hC0);
    chk(ctrl.strength, 8'hC0);
    chk(ctrl.pull_en & pai_pkg::PORT_MASK, 8'h0F);
    chk(ctrl.pull_down, 8'h00);
    rd_reg(pai_pkg::OFF_DATA, 8'hCF);
    // falling edge detection, pin 1 not selected
    wr_reg(SC, 8'h06);
    rd_reg(SC, 8'h02);
    ext_val <= 8'h0D;
    idle(6);
    rd_reg(SC, 8'h02);
    ext_val <= 8'h0C;
    wait_irq(1'b1);
    rd_reg(SC, 8'h0A);
    wr_reg(SC, 8'h02);
    rd_reg(SC, 8'h0A);
    wr_reg(SC, 8'h06);
    wait_irq(1'b0);
    rd_reg(SC, 8'h02);
    // detection with the request disabled
    wr_reg(SC, 8'h00);
    ext_val <= 8'h0D;
    idle(3);
    ext_val <= 8'h0C;
    idle(8);
    chk({7'h00, irq}, 8'h00);
    rd_reg(SC, 8'h08);
    wr_reg(SC, 8'h02);
    wait_irq(1'b1);
    // rising polarity picks pull-down on the selected pin only
    wr_reg(pai_pkg::OFF_POLARITY, 8'hFF);
    rd_reg(pai_pkg::OFF_POLARITY, 8'h0F);
    idle(2);
    chk(ctrl.pull_down, 8'h01);
    wr_reg(SC, 8'h06);
    wait_irq(1'b0);
    ext_val <= 8'h0D;
    wait_irq(1'b1);
    wr_reg(SC, 8'h06);
    wait_irq(1'b0);
    // level mode: held active level defeats the acknowledge
    wr_reg(SC, 8'h07);
    wait_irq(1'b1);
    wr_reg(SC, 8'h07);
    idle(2);
    rd_reg(SC, 8'h0B);
    ext_val <= 8'h0C;
    idle(6);
    wr_reg(SC, 8'h07);
    wait_irq(1'b0);
    rd_reg(SC, 8'h03);
    // reset in mid-run
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    rd_reg(SC, 8'h00);
    rd_reg(pai_pkg::OFF_SLEW, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
